// >>> design/blc_clamp_ctrl.sv
// module: clamp pulse generator, pulse steering and black level sequencing
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - analogue loop stays active four times duration pixels after enable falls.
// - then average error over two-power-exponent pixels, subtract until the next average is done.
// - computed average preloads the filter state to avoid a step.
// - vertical select clear gives power-down input, set gives frame sync.
// - horizontal select clear gives video blocking input, set gives line sync.
// - vertical select set forces pin power-down inactive, management request kept.
// - vertical select clear stops all frame-sync logic including steering.
// - horizontal select set holds internal video blocking inactive high.
// - horizontal select clear stops all line-sync dependent logic.
// - internal clamp select picks pin or internal pulses as loop enable.
// - pulse generator runs on master clock, triggered by trigger falling edges.
// - frame sync falling edge restarts the steering pulse count.
// - internal pulse rises delay plus one pixels after trigger falls.
// - internal pulse lasts exactly width pixels.
// - first offset-count pulses after frame sync go to the filter.
// - next line-count pulses go to the analogue loop enable.
// - any pulse not steered to the analogue loop goes to the filter unless block-filter is set.
// - block-analogue bit redirects analogue pulses to the filter.
// - block-filter bit stops every pulse reaching the filter enable.
// - gain-change-only limits analogue steering to the frame after gain write.
// - analogue duration is seven bits.
// - digital averaging exponent is three bits.
module blc_clamp_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic pixel_en,
	input wire logic clamp_trigger_n,
	input wire logic shared_vert_pin,
	input wire logic shared_horiz_pin,
	input wire logic gain_write,
	input wire logic [blc_pkg::DATA_W-1:0] adc_code,
	input wire blc_pkg::blc_cfg_t cfg,
	output logic power_down_n,
	output logic video_block_in,
	output logic frame_sync_in,
	output logic line_sync_in,
	output logic internal_clamp_pulse,
	output logic analog_loop_enable_n,
	output logic filter_enable_n,
	output logic [blc_pkg::DATA_W-1:0] corrected_code,
	output blc_pkg::blc_status_t status
);
	////////////////////////////////////////////////////////////////////////
	// dual mode pins
	logic vs_q;
	logic trig_q;
	logic pulse_q;
	logic trig_fall;
	logic vs_fall;
	logic pulse_fall;

	always_comb
	begin
		// pin polarity: power-down and blocking are active low inputs
		power_down_n = (cfg.vert_pin_select ? 1'b1 : shared_vert_pin)
			& ~cfg.mgmt_power_down;
		frame_sync_in = cfg.vert_pin_select ? shared_vert_pin : 1'b1;
		video_block_in = cfg.horiz_pin_select ? 1'b1 : shared_horiz_pin;
		line_sync_in = cfg.horiz_pin_select ? shared_horiz_pin : 1'b1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			vs_q <= 1'b1;
			trig_q <= 1'b1;
			pulse_q <= 1'b0;
		end
		else
		begin
			vs_q <= frame_sync_in;
			trig_q <= clamp_trigger_n;
			pulse_q <= internal_clamp_pulse;
		end
	end

	assign trig_fall = trig_q & ~clamp_trigger_n;
	assign vs_fall = cfg.vert_pin_select & vs_q & ~frame_sync_in;
	assign pulse_fall = internal_clamp_pulse & ~pulse_q;

	////////////////////////////////////////////////////////////////////////
	// internal clamp pulse generator, timed in pixel periods
	blc_pkg::blc_pg_t pg_state;
	logic [blc_pkg::CNT_W-1:0] pg_cnt;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pg_state <= blc_pkg::BLC_PG_IDLE;
			pg_cnt <= blc_pkg::CNT_ZERO;
			internal_clamp_pulse <= 1'b0;
		end
		else
		begin
			case (pg_state)
				blc_pkg::BLC_PG_IDLE:
				begin
					// zero width: trigger is dropped, nothing counted
					if (trig_fall && cfg.clamp_pulse_width != blc_pkg::CNT_ZERO)
					begin
						pg_state <= blc_pkg::BLC_PG_DELAY;
						pg_cnt <= cfg.clamp_pulse_delay;
					end
				end
				blc_pkg::BLC_PG_DELAY:
				begin
					if (pixel_en)
					begin
						if (pg_cnt == blc_pkg::CNT_ZERO)
						begin
							pg_state <= blc_pkg::BLC_PG_PULSE;
							internal_clamp_pulse <= 1'b1;
							pg_cnt <= cfg.clamp_pulse_width;
						end
						else
							pg_cnt <= pg_cnt - blc_pkg::CNT_ONE;
					end
				end
				blc_pkg::BLC_PG_PULSE:
				begin
					if (pixel_en)
					begin
						if (pg_cnt == blc_pkg::CNT_ONE)
						begin
							pg_state <= blc_pkg::BLC_PG_IDLE;
							internal_clamp_pulse <= 1'b0;
						end
						pg_cnt <= pg_cnt - blc_pkg::CNT_ONE;
					end
				end
				default:
				begin
					pg_state <= blc_pkg::BLC_PG_IDLE;
					internal_clamp_pulse <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// steering
	logic [blc_pkg::CNT_W:0] pulse_idx;
	logic gain_pending;
	logic gain_frame;
	logic to_analog;
	logic steer_latched;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pulse_idx <= '0;
		else if (!cfg.vert_pin_select)
			pulse_idx <= '0;
		else if (vs_fall)
			pulse_idx <= '0;
		else if (pulse_fall && !(&pulse_idx))
			pulse_idx <= pulse_idx + 9'h001;
	end

	// a gain write arms the next frame; the write wins over the frame edge
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			gain_pending <= 1'b0;
			gain_frame <= 1'b0;
		end
		else if (vs_fall)
		begin
			gain_frame <= gain_pending;
			gain_pending <= gain_write;
		end
		else if (gain_write)
			gain_pending <= 1'b1;
	end

	always_comb
	begin
		to_analog = cfg.vert_pin_select
			&& ({1'b0, cfg.analog_line_offset} <= pulse_idx)
			&& (pulse_idx < {1'b0, cfg.analog_line_offset}
				+ {1'b0, cfg.analog_line_count})
			&& !cfg.block_analog_steer
			&& (!cfg.gain_change_only || gain_frame);
	end

	// route decided at pulse start so it cannot flip mid-pulse
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			steer_latched <= 1'b0;
		else if (pulse_fall)
			steer_latched <= to_analog;
	end

	logic int_analog_n;
	logic int_filter_n;
	always_comb
	begin
		int_analog_n = ~(internal_clamp_pulse
			& (pulse_fall ? to_analog : steer_latched));
		int_filter_n = ~(internal_clamp_pulse
			& ~(pulse_fall ? to_analog : steer_latched)
			& ~cfg.block_filter_steer);
		analog_loop_enable_n = cfg.internal_clamp_select ? int_analog_n
			: clamp_trigger_n;
		filter_enable_n = int_filter_n;
	end

	////////////////////////////////////////////////////////////////////////
	// analogue then digital correction sequence
	logic ale_q;
	logic ale_fall;
	blc_pkg::blc_phase_t phase;
	logic [9:0] phase_cnt;
	logic [blc_pkg::ACC_W-1:0] acc;
	logic signed [blc_pkg::DATA_W:0] avg_error;
	logic preload;
	logic signed [blc_pkg::DATA_W:0] diff;
	logic signed [blc_pkg::ACC_W-1:0] acc_next;
	logic signed [blc_pkg::DATA_W+1:0] corr;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ale_q <= 1'b1;
		else
			ale_q <= analog_loop_enable_n;
	end
	assign ale_fall = ale_q & ~analog_loop_enable_n;

	assign diff = $signed({1'b0, adc_code}) - $signed({1'b0, cfg.black_target});
	assign acc_next = $signed(acc) + blc_pkg::ACC_W'(diff);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			phase <= blc_pkg::BLC_IDLE;
			phase_cnt <= '0;
			acc <= blc_pkg::ACC_ZERO;
			avg_error <= '0;
			preload <= 1'b0;
		end
		else
		begin
			preload <= 1'b0;
			case (phase)
				blc_pkg::BLC_IDLE:
				begin
					if (ale_fall)
					begin
						phase <= blc_pkg::BLC_ANALOG;
						phase_cnt <= {1'b0, cfg.analog_loop_duration, 2'b00};
					end
				end
				blc_pkg::BLC_ANALOG:
				begin
					if (pixel_en)
					begin
						if (phase_cnt <= 10'h001)
						begin
							phase <= blc_pkg::BLC_DIGITAL;
							phase_cnt <= 10'h001 << cfg.digital_avg_exponent;
							acc <= blc_pkg::ACC_ZERO;
						end
						else
							phase_cnt <= phase_cnt - 10'h001;
					end
				end
				blc_pkg::BLC_DIGITAL:
				begin
					if (pixel_en)
					begin
						acc <= acc_next;
						if (phase_cnt == 10'h001)
						begin
							phase <= blc_pkg::BLC_IDLE;
							avg_error <= (blc_pkg::DATA_W+1)'(acc_next
								>>> cfg.digital_avg_exponent);
							preload <= 1'b1;
						end
						phase_cnt <= phase_cnt - 10'h001;
					end
				end
				default:
					phase <= blc_pkg::BLC_IDLE;
			endcase
		end
	end

	// subtract the held average; clipped to the code range
	assign corr = $signed({2'b00, adc_code}) - $signed({avg_error[blc_pkg::DATA_W],
		avg_error});

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			corrected_code <= blc_pkg::DATA_ZERO;
		else if (pixel_en)
		begin
			if (corr[blc_pkg::DATA_W+1])
				corrected_code <= blc_pkg::DATA_ZERO;
			else if (corr[blc_pkg::DATA_W])
				corrected_code <= '1;
			else
				corrected_code <= corr[blc_pkg::DATA_W-1:0];
		end
	end

	always_comb
	begin
		status.analog_loop_active = (phase == blc_pkg::BLC_ANALOG);
		status.digital_avg_active = (phase == blc_pkg::BLC_DIGITAL);
		status.filter_enable = ~filter_enable_n;
		status.filter_preload = preload;
		status.avg_error = avg_error;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_VERT_PD: assert property (@(posedge clk) disable iff (reset)
		cfg.vert_pin_select && !cfg.mgmt_power_down |-> power_down_n)
		else $error("power down not forced inactive");
	AST_BLK_HIGH: assert property (@(posedge clk) disable iff (reset)
		cfg.horiz_pin_select |-> video_block_in)
		else $error("video blocking not held high");
	AST_NO_FILTER: assert property (@(posedge clk) disable iff (reset)
		cfg.block_filter_steer |-> filter_enable_n)
		else $error("pulse reached filter while blocked");
	AST_ZERO_WID: assert property (@(posedge clk) disable iff (reset)
		trig_fall && pg_state == blc_pkg::BLC_PG_IDLE
		&& cfg.clamp_pulse_width == blc_pkg::CNT_ZERO
		|=> pg_state == blc_pkg::BLC_PG_IDLE)
		else $error("zero width started a pulse");
	AST_PULSE_END: assert property (@(posedge clk) disable iff (reset)
		pg_state == blc_pkg::BLC_PG_PULSE && pixel_en && pg_cnt == blc_pkg::CNT_ONE
		|=> !internal_clamp_pulse)
		else $error("pulse width overrun");
	AST_FRAME_RST: assert property (@(posedge clk) disable iff (reset)
		vs_fall |=> pulse_idx == '0)
		else $error("steering count not restarted");
	AST_NO_VSYNC: assert property (@(posedge clk) disable iff (reset)
		!cfg.vert_pin_select |-> frame_sync_in ##1 pulse_idx == '0)
		else $error("frame logic ran without frame sync");
	AST_BLOCK_AN: assert property (@(posedge clk) disable iff (reset)
		cfg.block_analog_steer && $past(cfg.block_analog_steer)
		&& cfg.internal_clamp_select |-> analog_loop_enable_n)
		else $error("analogue pulse while blocked");
	AST_SRC_PIN: assert property (@(posedge clk) disable iff (reset)
		!cfg.internal_clamp_select |-> analog_loop_enable_n == clamp_trigger_n)
		else $error("loop enable not from pin");
	AST_DIG_START: assert property (@(posedge clk) disable iff (reset)
		phase == blc_pkg::BLC_ANALOG && pixel_en && phase_cnt <= 10'h001
		|=> phase == blc_pkg::BLC_DIGITAL)
		else $error("digital phase did not follow");
	AST_PRELOAD: assert property (@(posedge clk) disable iff (reset)
		preload |-> $past(phase) == blc_pkg::BLC_DIGITAL
		&& phase == blc_pkg::BLC_IDLE)
		else $error("preload outside end of averaging");
endmodule : blc_clamp_ctrl

// >>> dv/blc_tg_model.sv
// timing generator model: pixel strobe, clamp trigger and dual-mode pins
module blc_tg_model (
	input wire logic clk,
	output logic pixel_en,
	output logic clamp_trigger_n,
	output logic vert_pin,
	output logic horiz_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	longint trig_time = 0;
	initial
	begin
		pixel_en = 1'h1;
		clamp_trigger_n = 1'h1;
		vert_pin = 1'h1;
		horiz_pin = 1'h1;
	end
	// trigger stays low a few pixels, as a black-pixel window would
	task automatic clamp(input int low);
		@(posedge clk);
		#1 clamp_trigger_n = 1'h0;
		trig_time = $time + 49;
		repeat (low) @(posedge clk);
		#1 clamp_trigger_n = 1'h1;
	endtask : clamp
	// a frame starts before any clamp of that frame
	task automatic frame();
		@(posedge clk);
		#1 vert_pin = 1'h0;
		repeat (2) @(posedge clk);
		#1 vert_pin = 1'h1;
	endtask : frame
	task automatic pins(input logic v, input logic h);
		@(posedge clk);
		#1 vert_pin = v;
		horiz_pin = h;
	endtask : pins
endmodule : blc_tg_model

// >>> dv/tb.sv
// self-checking bench for the clamp pulse control block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic gain_write = 1'h0;
	logic [blc_pkg::DATA_W-1:0] adc_code = 10'h000;
	blc_pkg::blc_cfg_t cfg = '0;
	logic pixel_en, clamp_trigger_n, vpin, hpin, power_down_n, video_block_in;
	logic frame_sync_in, line_sync_in, internal_clamp_pulse;
	logic analog_loop_enable_n, filter_enable_n;
	logic [blc_pkg::DATA_W-1:0] corrected_code;
	blc_pkg::blc_status_t status;
	int error_cnt = 0;
	int comparisons = 0;
	logic [17:0] notes[$];
	logic [17:0] e;
	int pidx, m, k, wid, lat, an_cnt, dig_cnt, pre_cnt, tgt, err;
	logic fen;
	logic armed;
	logic prev_pulse = 1'h0;
	logic [1:0] rt;
	longint rise_t;
	initial
	begin
		forever #25 clk = ~clk;
	end
	blc_tg_model p (.clk(clk), .pixel_en(pixel_en),
		.clamp_trigger_n(clamp_trigger_n), .vert_pin(vpin), .horiz_pin(hpin));
	blc_clamp_ctrl dut (.clk(clk), .reset(reset), .pixel_en(pixel_en),
		.clamp_trigger_n(clamp_trigger_n), .shared_vert_pin(vpin),
		.shared_horiz_pin(hpin), .gain_write(gain_write),
		.adc_code(adc_code), .cfg(cfg), .power_down_n(power_down_n),
		.video_block_in(video_block_in), .frame_sync_in(frame_sync_in),
		.line_sync_in(line_sync_in),
		.internal_clamp_pulse(internal_clamp_pulse),
		.analog_loop_enable_n(analog_loop_enable_n),
		.filter_enable_n(filter_enable_n), .corrected_code(corrected_code),
		.status(status));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check
	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	// one trigger; the expected route is noted only for a pulse that exists
	task automatic shoot(input int d, input int w);
		logic an;
		tick();
		cfg.clamp_pulse_delay = d[7:0];
		cfg.clamp_pulse_width = w[7:0];
		if (w != 0)
		begin
			an = pidx >= cfg.analog_line_offset && !cfg.block_analog_steer &&
				pidx < cfg.analog_line_offset + cfg.analog_line_count &&
				(!cfg.gain_change_only || armed);
			notes.push_back({an, !an && !cfg.block_filter_steer, d[7:0], w[7:0]});
			pidx++;
		end
		p.clamp(3);
		repeat (d + w + 8) @(posedge clk);
	endtask : shoot
	// pulse monitor: width, delay from the trigger, and route
	// sampled on the falling edge so every output has settled
	always @(negedge clk)
	begin
		if (internal_clamp_pulse === 1'h1 && !prev_pulse)
		begin
			rise_t = $time;
			rt = {analog_loop_enable_n === 1'h0, filter_enable_n === 1'h0};
			fen = status.filter_enable;
			wid = 0;
		end
		if (internal_clamp_pulse === 1'h1)
			wid++;
		if (internal_clamp_pulse !== 1'h1 && prev_pulse)
		begin
			if (notes.size() == 0)
				check(1, 0, "unexpected pulse");
			else
			begin
				e = notes.pop_front();
				lat = int'((rise_t - p.trig_time) / 50);
				check(wid, e[7:0], "width");
				check(lat, e[15:8] + 1, "delay");
				check(rt, e[17:16], "route");
				check(fen, e[16], "filter flag");
			end
		end
		prev_pulse = internal_clamp_pulse === 1'h1;
		an_cnt += status.analog_loop_active === 1'h1;
		dig_cnt += status.digital_avg_active === 1'h1;
		pre_cnt += status.filter_preload === 1'h1;
		if (cfg.internal_clamp_select === 1'h0)
			check(analog_loop_enable_n, clamp_trigger_n, "pin enable");
	end
	initial
	begin
		#2000000;
		error_cnt++;
		final_report();
	end
	initial
	begin
		void'($urandom(32'hbc04_a950));
		repeat (5) @(posedge clk);
		#1 reset = 1'h0;
		for (m = 0; m < 16; m++)
		begin
			p.pins(m[3], 1'($urandom_range(1)));
			cfg.vert_pin_select = m[0];
			cfg.horiz_pin_select = m[1];
			cfg.mgmt_power_down = m[2];
			#5;
			check(power_down_n, (m[0] || m[3]) && !m[2], "pd");
			check(video_block_in, m[1] || hpin, "blk");
			check(frame_sync_in, m[0] ? m[3] : 1, "vs");
			check(line_sync_in, m[1] ? hpin : 1, "hs");
		end
		p.pins(1'h1, 1'h1);
		tick();
		cfg = '0;
		cfg.vert_pin_select = 1'h1;
		cfg.internal_clamp_select = 1'h1;
		cfg.analog_line_offset = 8'h02;
		cfg.analog_line_count = 8'h03;
		for (m = 0; m < 6; m++)
		begin
			tick();
			cfg.block_analog_steer = m == 1;
			cfg.block_filter_steer = m == 2;
			cfg.gain_change_only = m >= 3;
			gain_write = m == 4;
			tick();
			gain_write = 1'h0;
			p.frame();
			armed = m == 4;
			pidx = 0;
			for (k = 0; k < 7; k++)
				shoot($urandom_range(5), k == 3 ? 0 : $urandom_range(4, 1));
		end
		tick();
		tgt = $urandom_range(200, 100);
		err = $urandom_range(20, 1);
		cfg.internal_clamp_select = 1'h0;
		cfg.clamp_pulse_width = 8'h00;
		cfg.analog_loop_duration = 7'h03;
		cfg.digital_avg_exponent = 3'h2;
		cfg.black_target = tgt[9:0];
		adc_code = tgt[9:0] + err[9:0];
		an_cnt = 0;
		dig_cnt = 0;
		pre_cnt = 0;
		p.clamp(3);
		repeat (40) tick();
		check(an_cnt, 12, "analog span");
		check(dig_cnt, 4, "average span");
		check(pre_cnt, 1, "preload");
		check(status.avg_error, err, "avg");
		check(corrected_code, tgt, "corrected");
		check(notes.size(), 0, "pulses left");
		final_report();
	end
endmodule : tb

// >>> shared/blc_pkg.sv
// package: constants and carriers for the black level clamp pulse control
package blc_pkg;
	localparam int DATA_W = 10;
	localparam int CNT_W = 8;
	localparam int DUR_W = 7;
	localparam int EXP_W = 3;
	localparam int ACC_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [9:0] ANALOG_MULT_SHIFT = 10'h002;
	localparam logic [DATA_W-1:0] DATA_ZERO = 10'h000;
	localparam logic [ACC_W-1:0] ACC_ZERO = 20'h0_0000;
	localparam logic [ACC_W-1:0] ACC_ONE = 20'h0_0001;

	// software settings, held by the management interface outside this block
	typedef struct packed {
		logic vert_pin_select;
		logic horiz_pin_select;
		logic internal_clamp_select;
		logic block_analog_steer;
		logic block_filter_steer;
		logic gain_change_only;
		logic mgmt_power_down;
		logic [CNT_W-1:0] clamp_pulse_delay;
		logic [CNT_W-1:0] clamp_pulse_width;
		logic [CNT_W-1:0] analog_line_offset;
		logic [CNT_W-1:0] analog_line_count;
		logic [DUR_W-1:0] analog_loop_duration;
		logic [EXP_W-1:0] digital_avg_exponent;
		logic [DATA_W-1:0] black_target;
	} blc_cfg_t;

	// correction state shown to the datapath and to software
	typedef struct packed {
		logic analog_loop_active;
		logic digital_avg_active;
		logic filter_enable;
		logic filter_preload;
		logic signed [DATA_W:0] avg_error;
	} blc_status_t;

	typedef enum logic [1:0] {
		BLC_IDLE = 2'b00,
		BLC_ANALOG = 2'b01,
		BLC_DIGITAL = 2'b10
	} blc_phase_t;

	typedef enum logic [1:0] {
		BLC_PG_IDLE = 2'b00,
		BLC_PG_DELAY = 2'b01,
		BLC_PG_PULSE = 2'b10
	} blc_pg_t;
endpackage : blc_pkg
